/* File: lmv_pkg.sv */
`default_nettype none
package lmv_pkg;
    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_PAGE_BYTES   = 12'h028;
    localparam logic [11:0] OFS_QUEUE_SELECT = 12'h030;
    localparam logic [11:0] OFS_SIZE_LIMIT   = 12'h034;
    localparam logic [11:0] OFS_SIZE_SET     = 12'h038;
    localparam logic [11:0] OFS_USED_ALIGN   = 12'h03c;
    localparam logic [11:0] OFS_PAGE_FRAME   = 12'h040;
    localparam logic [11:0] OFS_DOORBELL     = 12'h050;
    localparam logic [11:0] OFS_IRQ_CAUSE    = 12'h060;
    localparam logic [11:0] OFS_IRQ_CLEAR    = 12'h064;
    localparam logic [11:0] OFS_DEV_STATUS   = 12'h070;
    localparam logic [11:0] OFS_CFG_BASE     = 12'h100;
    localparam logic [11:0] CFG_REGION_MASK  = 12'hf00;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int          NUM_QUEUES = 8;
    localparam int          QIDX_W     = 3;
    localparam int          CFG_WORDS  = 64;
    localparam int          CFG_IDX_W  = 6;
    localparam logic [31:0] NUM_QUEUES_W = 32'h0000_0008;

    // ------------------------------------------------------------------
    // reset values and fixed answers
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
    localparam logic [31:0] RST_PAGE_BYTES   = 32'h0000_1000;
    localparam logic [31:0] QUEUE_SIZE_LIMIT = 32'h0000_0100;

    // ------------------------------------------------------------------
    // interrupt cause bits
    // ------------------------------------------------------------------
    localparam int IRQ_USED_BIT   = 0;
    localparam int IRQ_CONFIG_BIT = 1;

    // ------------------------------------------------------------------
    // legacy ring layout
    // ------------------------------------------------------------------
    localparam logic [63:0] RING_BYTES_PER_ENTRY = 64'h0000_0000_0000_0012;
    localparam logic [63:0] AVAIL_FIXED_BYTES    = 64'h0000_0000_0000_0006;

    typedef enum logic [1:0] {
        LMV_FLD_SIZE  = 2'b00,
        LMV_FLD_ALIGN = 2'b01,
        LMV_FLD_FRAME = 2'b11
    } lmv_field_t;

    // guest address of a page frame
    function automatic logic [63:0] lmv_queue_addr(input logic [31:0] frame,
                                                   input logic [31:0] page);
        return {32'h0000_0000, frame} * {32'h0000_0000, page};
    endfunction

    // used ring start, rounded up to the alignment
    function automatic logic [63:0] lmv_used_addr(input logic [63:0] base,
                                                  input logic [31:0] num,
                                                  input logic [31:0] align);
        logic [63:0] raw;
        logic [63:0] mask;
        raw  = base + ({32'h0000_0000, num} * RING_BYTES_PER_ENTRY) + AVAIL_FIXED_BYTES;
        mask = (align == RST_ZERO) ? 64'h0 : ({32'h0000_0000, align} - 64'h1);
        return (raw + mask) & ~mask;
    endfunction
endpackage
`default_nettype wire

/* File: lmv_queue_table.sv */
`default_nettype none
module lmv_queue_table
    import lmv_pkg::*;
(
    input  wire logic                      clk,
    input  wire logic                      sys_rst,
    input  wire logic                      clear_all,
    input  wire logic                      wr_en,
    input  wire lmv_pkg::lmv_field_t       wr_field,
    input  wire logic [lmv_pkg::QIDX_W-1:0] wr_idx,
    input  wire logic [31:0]               wr_data,
    input  wire logic [lmv_pkg::QIDX_W-1:0] rd_idx,
    output logic      [31:0]               rd_frame,
    input  wire logic [lmv_pkg::QIDX_W-1:0] lk_idx,
    output logic      [31:0]               lk_frame,
    output logic      [31:0]               lk_size,
    output logic      [31:0]               lk_align
);
    import lmv_pkg::*;

    // ------------------------------------------------------------------
    // per-queue storage
    // ------------------------------------------------------------------
    logic [31:0] frame_q [NUM_QUEUES];
    logic [31:0] size_q  [NUM_QUEUES];
    logic [31:0] align_q [NUM_QUEUES];

    always_ff @(posedge clk) begin
        if (sys_rst || clear_all) begin
            for (int i = 0; i < NUM_QUEUES; i++) begin
                frame_q[i] <= RST_ZERO;
                size_q[i]  <= RST_ZERO;
                align_q[i] <= RST_ZERO;
            end
        end else if (wr_en) begin
            unique case (wr_field)
                LMV_FLD_SIZE:  size_q[wr_idx]  <= wr_data;
                LMV_FLD_ALIGN: align_q[wr_idx] <= wr_data;
                LMV_FLD_FRAME: frame_q[wr_idx] <= wr_data;
                default:       frame_q[wr_idx] <= frame_q[wr_idx];
            endcase
        end
    end

    assign rd_frame = frame_q[rd_idx];
    assign lk_frame = frame_q[lk_idx];
    assign lk_size  = size_q[lk_idx];
    assign lk_align = align_q[lk_idx];
endmodule // lmv_queue_table
`default_nettype wire

/* File: lmv_config_space.sv */
`default_nettype none
module lmv_config_space
    import lmv_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         wr_en,
    input  wire logic [lmv_pkg::CFG_IDX_W-1:0] wr_idx,
    input  wire logic [31:0]                  wr_data,
    input  wire logic [lmv_pkg::CFG_IDX_W-1:0] rd_idx,
    output logic      [31:0]                  rd_data,
    input  wire logic [lmv_pkg::CFG_IDX_W-1:0] dev_idx,
    output logic      [31:0]                  dev_data
);
    import lmv_pkg::*;

    // ------------------------------------------------------------------
    // configuration words
    // ------------------------------------------------------------------
    logic [31:0] mem_q [CFG_WORDS];
    logic [31:0] dev_data_q;

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
        dev_data_q <= mem_q[dev_idx];
    end

    assign rd_data  = mem_q[rd_idx];
    assign dev_data = dev_data_q;
endmodule // lmv_config_space
`default_nettype wire

/* File: lmv_regs.sv */
//
// Function
// - page-frame write stores the guest page index of the selected queue
// - page frame zero means no queue; zero is never an active placement
// - page-frame read returns the selected queue's page; non-zero means active
// - page-frame reads and writes act on the selected queue, one value each
// - status read returns the current status flags
// - non-zero status write sets the written flags
// - zero status write starts a device reset; configuration space words keep their values
// - device reset clears every queue's page frame to zero
// - used ring placed at the latest alignment written for that queue
// - size limit reads zero for unavailable queue; driver then skips it
// - queue address is page frame times guest page size
// - queue select picks the queue for limit, size, alignment, page frame
// - interrupt output high while any cause bit is set
//
`default_nettype none
module lmv_regs
    import lmv_pkg::*;
(
    input  wire logic                         clk,
    input  wire logic                         sys_rst,
    // register port
    input  wire logic                         reg_wr_en,
    input  wire logic                         reg_rd_en,
    input  wire logic [11:0]                  reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    output logic      [31:0]                  reg_rdata,
    output logic                              reg_rd_valid,
    // interrupt
    output logic                              irq,
    input  wire logic                         used_event,
    input  wire logic                         config_event,
    // queue processing side
    output logic                              doorbell_valid,
    output logic      [31:0]                  doorbell_queue,
    output logic                              dev_reset,
    output logic      [31:0]                  dev_status,
    input  wire logic [lmv_pkg::QIDX_W-1:0]   lookup_idx,
    output logic                              lookup_active,
    output logic      [63:0]                  lookup_desc_addr,
    output logic      [63:0]                  lookup_used_addr,
    output logic      [31:0]                  lookup_size,
    input  wire logic [lmv_pkg::CFG_IDX_W-1:0] cfg_dev_idx,
    output logic      [31:0]                  cfg_dev_data
);
    import lmv_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [31:0] page_bytes_q;
    logic [31:0] page_bytes_d;

    logic [31:0] select_q;
    logic [31:0] select_d;

    logic [31:0] status_q;
    logic [31:0] status_d;

    logic [31:0] cause_q;
    logic [31:0] cause_d;

    logic [31:0] rdata_q;
    logic        rd_valid_q;

    logic        bell_q;
    logic [31:0] bell_idx_q;
    logic        reset_q;

    logic        active_q;
    logic [63:0] desc_addr_q;
    logic [63:0] used_addr_q;
    logic [31:0] size_q;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire hit_page_bytes = (reg_addr == OFS_PAGE_BYTES);
    wire hit_select     = (reg_addr == OFS_QUEUE_SELECT);

    wire hit_limit      = (reg_addr == OFS_SIZE_LIMIT);
    wire hit_size       = (reg_addr == OFS_SIZE_SET);
    wire hit_align      = (reg_addr == OFS_USED_ALIGN);
    wire hit_frame      = (reg_addr == OFS_PAGE_FRAME);

    wire hit_bell       = (reg_addr == OFS_DOORBELL);

    wire hit_cause      = (reg_addr == OFS_IRQ_CAUSE);
    wire hit_clear      = (reg_addr == OFS_IRQ_CLEAR);

    wire hit_status     = (reg_addr == OFS_DEV_STATUS);
    wire hit_cfg        = ((reg_addr & CFG_REGION_MASK) == OFS_CFG_BASE);

    wire                 sel_valid = (select_q < NUM_QUEUES_W);
    wire [QIDX_W-1:0]    sel_idx   = select_q[QIDX_W-1:0];
    wire [CFG_IDX_W-1:0] cfg_idx   = reg_addr[CFG_IDX_W+1:2];

    // ------------------------------------------------------------------
    // write strobes
    // ------------------------------------------------------------------
    wire wr_page_bytes = reg_wr_en && hit_page_bytes;
    wire wr_select     = reg_wr_en && hit_select;
    wire wr_bell       = reg_wr_en && hit_bell;

    wire wr_status   = reg_wr_en && hit_status;
    wire wr_reset    = wr_status && (reg_wdata == RST_ZERO);
    wire wr_flags    = wr_status && (reg_wdata != RST_ZERO);

    wire wr_clear    = reg_wr_en && hit_clear;
    wire wr_cfg      = reg_wr_en && hit_cfg;

    // size, alignment and page frame of the selected queue
    wire wr_queue    = reg_wr_en
                    && sel_valid
                    && (hit_size || hit_align || hit_frame);

    lmv_field_t wr_field;
    assign wr_field = hit_frame ? LMV_FLD_FRAME :
                      hit_align ? LMV_FLD_ALIGN :
                                  LMV_FLD_SIZE;

    // ------------------------------------------------------------------
    // queue table and configuration space
    // ------------------------------------------------------------------
    logic [31:0] sel_frame;
    logic [31:0] lk_frame;
    logic [31:0] lk_size;
    logic [31:0] lk_align;
    logic [31:0] cfg_rdata;

    lmv_queue_table u_queues (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .clear_all (wr_reset),
        .wr_en     (wr_queue),
        .wr_field  (wr_field),
        .wr_idx    (sel_idx),
        .wr_data   (reg_wdata),
        .rd_idx    (sel_idx),
        .rd_frame  (sel_frame),
        .lk_idx    (lookup_idx),
        .lk_frame  (lk_frame),
        .lk_size   (lk_size),
        .lk_align  (lk_align)
    );

    lmv_config_space u_config (
        .clk      (clk),
        .wr_en    (wr_cfg),
        .wr_idx   (cfg_idx),
        .wr_data  (reg_wdata),
        .rd_idx   (cfg_idx),
        .rd_data  (cfg_rdata),
        .dev_idx  (cfg_dev_idx),
        .dev_data (cfg_dev_data)
    );

    // ------------------------------------------------------------------
    // next values
    // ------------------------------------------------------------------
    wire [31:0] cause_set = {30'h0, config_event, used_event};
    wire [31:0] cause_clr = wr_clear ? reg_wdata : RST_ZERO;

    assign page_bytes_d = wr_reset      ? RST_PAGE_BYTES :
                          wr_page_bytes ? reg_wdata :
                                          page_bytes_q;

    assign select_d     = wr_reset  ? RST_ZERO :
                          wr_select ? reg_wdata :
                                      select_q;

    assign status_d     = wr_reset ? RST_ZERO :
                          wr_flags ? (status_q | reg_wdata) :
                                     status_q;

    // set wins over acknowledge
    assign cause_d      = wr_reset ? cause_set :
                          ((cause_q & ~cause_clr) | cause_set);

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    wire [31:0] limit_val = sel_valid ? QUEUE_SIZE_LIMIT : RST_ZERO;
    wire [31:0] frame_val = sel_valid ? sel_frame : RST_ZERO;

    wire [31:0] rd_mux    = hit_limit  ? limit_val :
                            hit_frame  ? frame_val :
                            hit_cause  ? cause_q :
                            hit_status ? status_q :
                            hit_cfg    ? cfg_rdata : RST_ZERO;

    // ------------------------------------------------------------------
    // lookup for queue processing
    // ------------------------------------------------------------------
    wire [63:0] lk_base = lmv_queue_addr(lk_frame, page_bytes_q);
    wire [63:0] lk_used = lmv_used_addr(lk_base, lk_size, lk_align);
    wire        lk_live = (lk_frame != RST_ZERO);

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            page_bytes_q <= RST_PAGE_BYTES;
        end else begin
            page_bytes_q <= page_bytes_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            select_q <= RST_ZERO;
        end else begin
            select_q <= select_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_q <= RST_ZERO;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cause_q <= RST_ZERO;
        end else begin
            cause_q <= cause_d;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q    <= RST_ZERO;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= reg_rd_en;
            if (reg_rd_en) begin
                rdata_q <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            bell_q     <= 1'b0;
            bell_idx_q <= RST_ZERO;
            reset_q    <= 1'b0;
        end else begin
            bell_q  <= wr_bell;
            reset_q <= wr_reset;
            if (wr_bell) begin
                bell_idx_q <= reg_wdata;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            active_q    <= 1'b0;
            desc_addr_q <= 64'h0;
            used_addr_q <= 64'h0;
            size_q      <= RST_ZERO;
        end else begin
            active_q    <= lk_live && !wr_reset;
            desc_addr_q <= lk_base;
            used_addr_q <= lk_used;
            size_q      <= lk_size;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata        = rdata_q;
    assign reg_rd_valid     = rd_valid_q;

    assign irq              = (cause_q != RST_ZERO);

    assign doorbell_valid   = bell_q;
    assign doorbell_queue   = bell_idx_q;
    assign dev_reset        = reset_q;
    assign dev_status       = status_q;

    assign lookup_active    = active_q;
    assign lookup_desc_addr = desc_addr_q;
    assign lookup_used_addr = used_addr_q;
    assign lookup_size      = size_q;
endmodule // lmv_regs
`default_nettype wire

/* File: lmv_regs_chk.sv */
`default_nettype none
module lmv_regs_chk
    import lmv_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        reg_wr_en,
    input wire logic        reg_rd_en,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_rd_valid,
    input wire logic        irq,
    input wire logic        used_event,
    input wire logic        doorbell_valid,
    input wire logic [31:0] doorbell_queue,
    input wire logic        dev_reset,
    input wire logic [31:0] dev_status,
    input wire logic        lookup_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------
    // access decode and sequences
    // ------------------------------------------------------------------
    wire logic db_wr = reg_wr_en && (reg_addr == OFS_DOORBELL);
    wire logic st_wr = reg_wr_en && (reg_addr == OFS_DEV_STATUS);
    sequence s_zero_wr; st_wr && (reg_wdata == RST_ZERO); endsequence
    sequence s_set_wr; st_wr && (reg_wdata != RST_ZERO); endsequence
    sequence s_db_out; doorbell_valid && (doorbell_queue == $past(reg_wdata)); endsequence
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    AST_RD_ANSWER: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered");
    AST_RD_QUIET: assert property (!reg_rd_en |=> !reg_rd_valid)
        else $error("read answer without request");
    AST_STATUS_READ: assert property (reg_rd_en && reg_addr == OFS_DEV_STATUS
        |=> reg_rdata == $past(dev_status)) else $error("status read differs");
    AST_STATUS_SET: assert property (s_set_wr
        |=> (dev_status & $past(reg_wdata)) == $past(reg_wdata)) else $error("flags not set");
    AST_SOFT_RESET: assert property (s_zero_wr |=> dev_reset && dev_status == RST_ZERO)
        else $error("zero status write did not reset");
    AST_FRAMES_CLEAR: assert property (s_zero_wr |=> !lookup_active)
        else $error("queue active after reset");
    AST_IRQ_SET: assert property (used_event |=> irq)
        else $error("irq low with cause set");
    AST_DOORBELL: assert property (db_wr |=> s_db_out)
        else $error("doorbell not reported");
    AST_DOORBELL_IDLE: assert property (!db_wr |=> !doorbell_valid)
        else $error("doorbell without write");
endmodule // lmv_regs_chk

bind lmv_regs lmv_regs_chk i_chk (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .irq(irq), .used_event(used_event),
    .doorbell_valid(doorbell_valid), .doorbell_queue(doorbell_queue), .dev_reset(dev_reset),
    .dev_status(dev_status), .lookup_active(lookup_active));
`default_nettype wire

/* File: lmv_host.sv */
`default_nettype none
module lmv_host
    import lmv_pkg::*;
(
    input  wire logic        clk,
    output var  logic        reg_wr_en,
    output var  logic        reg_rd_en,
    output var  logic [11:0] reg_addr,
    output var  logic [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata,
    input  wire logic        reg_rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 12'h000;
        reg_wdata = 32'h0;
    end
    // ------------------------------------------------------------------
    // bus cycles, idle bus shows inverted values
    // ------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        ok = 1'b0;
        d = 32'h0;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(negedge clk);
            reg_rd_en = 1'b0;
            if (reg_rd_valid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end
        end
        reg_addr = ~a;
    endtask
    // ------------------------------------------------------------------
    // queue bring-up in driver order
    // ------------------------------------------------------------------
    task automatic cfg_queue(input logic [2:0] q, input logic [31:0] num, al, pfn,
                             output logic [31:0] f0, lim);
        logic ok;
        wr(OFS_QUEUE_SELECT, {29'h0, q});
        rd(OFS_PAGE_FRAME, f0, ok);
        rd(OFS_SIZE_LIMIT, lim, ok);
        if (lim != RST_ZERO) begin
            wr(OFS_SIZE_SET, (num > lim) ? lim : num);
            wr(OFS_USED_ALIGN, al);
            wr(OFS_PAGE_FRAME, pfn);
        end
    endtask
endmodule // lmv_host
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench
    import lmv_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, sys_rst, reg_wr_en, reg_rd_en, reg_rd_valid, irq;
    logic        used_event, config_event, doorbell_valid, dev_reset, lookup_active;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, doorbell_queue, dev_status, lookup_size;
    logic [31:0] cfg_dev_data, f0, lim;
    logic [63:0] lookup_desc_addr, lookup_used_addr;
    logic [2:0]  lookup_idx;
    logic [5:0]  cfg_dev_idx;
    int          err_count, check_count;

    lmv_regs i_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .irq(irq),
        .used_event(used_event), .config_event(config_event),
        .doorbell_valid(doorbell_valid), .doorbell_queue(doorbell_queue),
        .dev_reset(dev_reset), .dev_status(dev_status), .lookup_idx(lookup_idx),
        .lookup_active(lookup_active), .lookup_desc_addr(lookup_desc_addr),
        .lookup_used_addr(lookup_used_addr), .lookup_size(lookup_size),
        .cfg_dev_idx(cfg_dev_idx), .cfg_dev_data(cfg_dev_data));
    lmv_host i_host (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid));
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk32(input logic [31:0] g, e); chk64({32'h0, g}, {32'h0, e}); endtask
    task automatic chk1(input logic g, e); chk64({63'h0, g}, {63'h0, e}); endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic        ok;
        i_host.rd(a, d, ok);
        chk1(ok, 1'b1);
        chk32(d, exp);
    endtask
    task automatic look(input logic [2:0] q);
        @(negedge clk);
        lookup_idx = q;
        @(negedge clk);
    endtask
    task automatic ev(input logic u, c);
        @(negedge clk);
        used_event = u;
        config_event = c;
        @(negedge clk);
        used_event = 1'b0;
        config_event = 1'b0;
    endtask
    task automatic done(input string n); $display("test %s finished", n); endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        used_event = 1'b0;
        config_event = 1'b0;
        lookup_idx = 3'h0;
        cfg_dev_idx = 6'h00;
        err_count = 0;
        check_count = 0;
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        rchk(OFS_DEV_STATUS, RST_ZERO);
        rchk(OFS_IRQ_CAUSE, RST_ZERO);
        chk1(irq, 1'b0);
        done("reset");
        i_host.wr(OFS_PAGE_BYTES, 32'h0000_2000);
        i_host.cfg_queue(3'h2, 32'h0000_0080, 32'h0000_1000, 32'h0000_0010, f0, lim);
        chk32(f0, RST_ZERO);
        chk32(lim, QUEUE_SIZE_LIMIT);
        rchk(OFS_PAGE_FRAME, 32'h0000_0010);
        i_host.wr(OFS_QUEUE_SELECT, 32'h0000_0003);
        rchk(OFS_PAGE_FRAME, RST_ZERO);
        i_host.wr(OFS_PAGE_FRAME, 32'h0000_0022);
        i_host.wr(OFS_QUEUE_SELECT, 32'h0000_0002);
        rchk(OFS_PAGE_FRAME, 32'h0000_0010);
        look(3'h2);
        chk1(lookup_active, 1'b1);
        chk64(lookup_desc_addr, 64'h0000_0000_0002_0000);
        chk64(lookup_used_addr, 64'h0000_0000_0002_1000);
        chk32(lookup_size, 32'h0000_0080);
        i_host.wr(OFS_USED_ALIGN, 32'h0000_0100);
        look(3'h3);
        chk64(lookup_desc_addr, 64'h0000_0000_0004_4000);
        look(3'h2);
        chk64(lookup_used_addr, 64'h0000_0000_0002_0a00);
        i_host.wr(OFS_PAGE_FRAME, RST_ZERO);
        look(3'h2);
        chk1(lookup_active, 1'b0);
        i_host.wr(OFS_QUEUE_SELECT, 32'h0000_0009);
        rchk(OFS_SIZE_LIMIT, RST_ZERO);
        done("queues");
        i_host.wr(OFS_DOORBELL, 32'h0000_0007);
        chk1(doorbell_valid, 1'b1);
        chk32(doorbell_queue, 32'h0000_0007);
        @(negedge clk);
        chk1(doorbell_valid, 1'b0);
        rchk(OFS_DOORBELL, RST_ZERO);
        done("doorbell");
        ev(1'b1, 1'b0);
        chk1(irq, 1'b1);
        ev(1'b0, 1'b1);
        rchk(OFS_IRQ_CAUSE, 32'h0000_0003);
        i_host.wr(OFS_IRQ_CLEAR, 32'h0000_0001);
        rchk(OFS_IRQ_CAUSE, 32'h0000_0002);
        chk1(irq, 1'b1);
        i_host.wr(OFS_IRQ_CLEAR, 32'h0000_0002);
        chk1(irq, 1'b0);
        done("interrupt");
        i_host.wr(OFS_DEV_STATUS, 32'h0000_0001);
        i_host.wr(OFS_DEV_STATUS, 32'h0000_0004);
        rchk(OFS_DEV_STATUS, 32'h0000_0005);
        chk32(dev_status, 32'h0000_0005);
        i_host.wr(OFS_QUEUE_SELECT, 32'h0000_0001);
        i_host.wr(OFS_PAGE_FRAME, 32'h0000_0033);
        i_host.wr(OFS_DEV_STATUS, RST_ZERO);
        chk1(dev_reset, 1'b1);
        rchk(OFS_DEV_STATUS, RST_ZERO);
        i_host.wr(OFS_QUEUE_SELECT, 32'h0000_0001);
        rchk(OFS_PAGE_FRAME, RST_ZERO);
        look(3'h1);
        chk1(lookup_active, 1'b0);
        done("status");
        i_host.wr(OFS_CFG_BASE + 12'h004, 32'hdead_beef);
        rchk(OFS_CFG_BASE + 12'h004, 32'hdead_beef);
        @(negedge clk);
        cfg_dev_idx = 6'h01;
        @(negedge clk);
        chk32(cfg_dev_data, 32'hdead_beef);
        rchk(12'h0f0, RST_ZERO);
        done("config");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
